// ===== stop_ctl_assertions.sv
/*
 * Port checker for the stop-mode clock gating controller.
 * Assumes it is bound onto stop_mode_clock_gating and sees only its ports.
 */
`timescale 1ns/1ps
`default_nettype none

module stop_ctl_checker
    import stop_ctl_pkg::*;
(
    input wire logic       core_clk,
    input wire logic       reset,
    input wire logic       clk_en,
    input wire logic       stop_request,
    input wire logic       wake_request,
    input wire logic       debug_enable,
    input wire logic       lowvolt_detect_enable,
    input wire logic       lowvolt_stop_enable,
    input wire logic [3:0] rtc_prescale_select,
    input wire logic [1:0] stop_mode_ff,
    input wire logic       periph_clock_run_ff,
    input wire logic       debug_clock_run_ff,
    input wire logic       regulator_active_ff,
    input wire logic       io_hold_ff,
    input wire logic       ram_retain_ff,
    input wire logic       usb_ram_retain_ff,
    input wire logic       standby_retain_ff,
    input wire logic       periph_power_off_ff,
    input wire logic       illegal_opcode_reset_ff,
    input wire logic [1:0] rtc_state_ff,
    input wire logic [1:0] usb_state_ff
);
    logic [1:0] prev_mode_ff;
    wire        entry;

    // The previous mode marks the first cycle of a stop, where entry decisions show.
    always_ff @(posedge core_clk) begin
        prev_mode_ff <= stop_mode_ff;
    end
    assign entry = (prev_mode_ff == 2'h0) && (stop_mode_ff != 2'h0);

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (reset);

    AST_PERIPH_GATED: assert property (stop_mode_ff != 2'h0 |-> !periph_clock_run_ff)
        else $error("peripheral clocks run in stop");
    AST_DEBUG_LIGHT: assert property (entry && $past(debug_enable) |->
        stop_mode_ff == 2'h1 && debug_clock_run_ff) else $error("debug stop entry wrong");
    AST_LVD_LIGHT: assert property (entry
        && $past(lowvolt_detect_enable && lowvolt_stop_enable)
        |-> stop_mode_ff == 2'h1 && regulator_active_ff) else $error("detector stop wrong");
    // A pulse frozen by a low enable outlives its request, so only fresh pulses are judged.
    AST_ILLEGAL: assert property (illegal_opcode_reset_ff && $past(clk_en) |->
        $past(stop_request) && stop_mode_ff == 2'h0) else $error("illegal reset without cause");
    AST_RTC_KEEP: assert property (entry |-> rtc_state_ff ==
        (($past(rtc_prescale_select) != 4'h0) ? PERIPH_ON : PERIPH_OFF)) else $error("rtc state");
    AST_RETAIN: assert property (stop_mode_ff != 2'h0 |->
        io_hold_ff && ram_retain_ff && usb_ram_retain_ff) else $error("retention missing");
    AST_DEEP_OFF: assert property (stop_mode_ff == 2'h3 |->
        periph_power_off_ff && !standby_retain_ff && usb_state_ff == PERIPH_OFF)
        else $error("deep stop not off");
    AST_WAKE: assert property (clk_en && wake_request && stop_mode_ff != 2'h0 |=>
        stop_mode_ff == 2'h0 && periph_clock_run_ff) else $error("wake did not restore run");
endmodule

bind stop_mode_clock_gating stop_ctl_checker i_chk (.core_clk(core_clk), .reset(reset),
    .clk_en(clk_en), .stop_request(stop_request), .wake_request(wake_request),
    .debug_enable(debug_enable), .lowvolt_detect_enable(lowvolt_detect_enable),
    .lowvolt_stop_enable(lowvolt_stop_enable), .rtc_prescale_select(rtc_prescale_select),
    .stop_mode_ff(stop_mode_ff), .periph_clock_run_ff(periph_clock_run_ff),
    .debug_clock_run_ff(debug_clock_run_ff), .regulator_active_ff(regulator_active_ff),
    .io_hold_ff(io_hold_ff), .ram_retain_ff(ram_retain_ff), .usb_ram_retain_ff(usb_ram_retain_ff),
    .standby_retain_ff(standby_retain_ff), .periph_power_off_ff(periph_power_off_ff),
    .illegal_opcode_reset_ff(illegal_opcode_reset_ff), .rtc_state_ff(rtc_state_ff),
    .usb_state_ff(usb_state_ff));

`default_nettype wire

// ===== stop_ctl_pkg.sv
/*
 * Shared constants for the stop-mode clock and power controller: register
 * offsets, field positions, reset values, mode codes and peripheral states.
 * Assumes nothing of its surroundings; every design file imports it whole.
 */
package stop_ctl_pkg;

    // Register bus geometry.
    localparam int ADDR_W = 4;
    localparam int DATA_W = 8;

    // Register offsets.
    localparam logic [3:0] CTRL_OFFSET   = 4'h0;
    localparam logic [3:0] STATUS_OFFSET = 4'h1;

    // Control register fields and reset value.
    localparam int         CTRL_STOP_ENABLE_BIT = 0;
    localparam int         CTRL_POWERDOWN_BIT   = 1;
    localparam logic [7:0] CTRL_RESET           = 8'h00;

    // Status register fields.
    localparam int STATUS_MODE_LSB     = 0;
    localparam int STATUS_ILLEGAL_BIT  = 2;
    localparam int STATUS_REGULATOR_BIT = 3;
    localparam int STATUS_DEBUG_BIT    = 4;

    // Per-peripheral power state codes.
    localparam logic [1:0] PERIPH_OFF     = 2'h0;
    localparam logic [1:0] PERIPH_STANDBY = 2'h1;
    localparam logic [1:0] PERIPH_ON      = 2'h2;

    // Peripheral slots of the policy array.
    localparam int NUM_PERIPH   = 6;
    localparam int SLOT_ADC     = 0;
    localparam int SLOT_COMP    = 1;
    localparam int SLOT_CLKGEN  = 2;
    localparam int SLOT_RTC     = 3;
    localparam int SLOT_OSC     = 4;
    localparam int SLOT_USB     = 5;

    // Operating modes, Gray coded along run -> light stop -> deep stop.
    typedef enum logic [1:0] {
        MODE_RUN        = 2'h0,
        MODE_LIGHT_STOP = 2'h1,
        MODE_DEEP_STOP  = 2'h3
    } stop_mode_t;

endpackage

// ===== stop_mode_clock_gating.sv
/*
 * Stop-mode clock gating and power policy controller.
 * Assumes the enable bits from other modules are synchronous to core_clk and
 * that stop_request and wake_request are one-cycle pulses from the CPU core.
 */
// The implementer's own choices: the strobed register port and the register offsets.
// Functional notes
// - Entering either stop mode turns off the system clocks to all peripherals.
// - With debug enabled, the debug logic keeps its clock in stop while peripherals halt.
// - In light stop the converter runs only with its async clock and the detector on, else standby; deep stop turns it off.
// - In light stop the comparator with bandgap selected stays active only with the detector on, else standby.
// - In light stop the clock generator stays on only with both internal-reference enables, else standby.
// - In both stops the real-time counter runs only if its prescale select is nonzero at entry, else off.
// - In light stop the oscillator stays on only with both external-reference enables, else standby.
// - In its high-frequency range the oscillator also needs the detector to stay on in light stop.
// - In light stop USB stays on only with module and PHY enables, else off; deep stop turns it off.
// - Debug enabled at a stop request forces light stop even when deep stop was chosen.
// - Detector and its stop enable both set keep the regulator active and force light stop.
// - A stop request with stop disabled raises an illegal-opcode reset and enters no stop.
// - Otherwise the power-down control picks deep stop when 1 and light stop when 0.
`timescale 1ns/1ps
`default_nettype none

module stop_mode_clock_gating
    import stop_ctl_pkg::*;
(
    input  wire logic                core_clk,
    input  wire logic                reset,
    input  wire logic                clk_en,
    input  wire logic [ADDR_W-1:0]   reg_addr,
    input  wire logic [DATA_W-1:0]   reg_wdata,
    input  wire logic                reg_write,
    input  wire logic                reg_read,
    output logic      [DATA_W-1:0]   reg_rdata_ff,
    input  wire logic                stop_request,
    input  wire logic                wake_request,
    input  wire logic                debug_enable,
    input  wire logic                lowvolt_detect_enable,
    input  wire logic                lowvolt_stop_enable,
    input  wire logic                adc_async_clock_enable,
    input  wire logic                comparator_enable,
    input  wire logic                comparator_bandgap_select,
    input  wire logic                internal_ref_clock_enable,
    input  wire logic                internal_ref_stop_enable,
    input  wire logic [3:0]          rtc_prescale_select,
    input  wire logic                external_ref_clock_enable,
    input  wire logic                external_ref_stop_enable,
    input  wire logic                osc_high_range,
    input  wire logic                usb_module_enable,
    input  wire logic                usb_phy_enable,
    output logic      [1:0]          stop_mode_ff,
    output logic                     periph_clock_run_ff,
    output logic                     debug_clock_run_ff,
    output logic                     regulator_active_ff,
    output logic                     io_hold_ff,
    output logic                     ram_retain_ff,
    output logic                     usb_ram_retain_ff,
    output logic                     standby_retain_ff,
    output logic                     periph_power_off_ff,
    output logic                     illegal_opcode_reset_ff,
    output logic      [1:0]          adc_state_ff,
    output logic      [1:0]          comparator_state_ff,
    output logic      [1:0]          clockgen_state_ff,
    output logic      [1:0]          rtc_state_ff,
    output logic      [1:0]          osc_state_ff,
    output logic      [1:0]          usb_state_ff
);

    stop_mode_t               mode_ff;
    stop_mode_t               nxt_mode;
    logic [DATA_W-1:0]        ctrl_ff;
    logic                     illegal_flag_ff;
    logic                     debug_at_entry_ff;
    logic                     lvd_at_entry_ff;
    logic [NUM_PERIPH-1:0]    keep_ff;
    logic [NUM_PERIPH-1:0]    keep_now;
    logic [NUM_PERIPH-1:0]    deep_allowed;
    logic [1:0]               light_fallback [NUM_PERIPH];
    logic [1:0]               periph_state [NUM_PERIPH];
    logic                     lvd_in_stop;
    logic                     stop_ok;
    logic                     stop_refused;
    logic                     go_light;
    logic                     entering;
    logic                     in_light;
    logic                     in_deep;
    logic                     in_stop;
    logic                     wr_ctrl;
    logic                     wr_status;
    logic                     clear_illegal;
    logic [DATA_W-1:0]        status_word;
    logic [DATA_W-1:0]        read_word;

    // Register decode: one write-strobe term per register.
    function automatic logic hit(input logic [ADDR_W-1:0] addr, input logic [3:0] offset);
        hit = (addr == offset);
    endfunction

    assign wr_ctrl       = reg_write && hit(reg_addr, CTRL_OFFSET);
    assign wr_status     = reg_write && hit(reg_addr, STATUS_OFFSET);
    assign clear_illegal = wr_status && reg_wdata[STATUS_ILLEGAL_BIT];

    // The detector counts as enabled for stop only with both of its enables.
    assign lvd_in_stop  = lowvolt_detect_enable && lowvolt_stop_enable;
    assign stop_ok      = stop_request && ctrl_ff[CTRL_STOP_ENABLE_BIT] && (mode_ff == MODE_RUN);
    assign stop_refused = stop_request && !ctrl_ff[CTRL_STOP_ENABLE_BIT]
                          && (mode_ff == MODE_RUN);
    // Debug or the stop-enabled detector override the deep choice.
    assign go_light     = debug_enable || lvd_in_stop
                          || !ctrl_ff[CTRL_POWERDOWN_BIT];
    assign entering     = stop_ok;

    // Mode sequencing: a wake request in either stop mode returns to run.
    always_comb begin
        nxt_mode = mode_ff;
        unique case (mode_ff)
            MODE_RUN: begin
                if (stop_ok) begin
                    nxt_mode = go_light ? MODE_LIGHT_STOP : MODE_DEEP_STOP;
                end
            end
            MODE_LIGHT_STOP: begin
                if (wake_request) begin
                    nxt_mode = MODE_RUN;
                end
            end
            MODE_DEEP_STOP: begin
                if (wake_request) begin
                    nxt_mode = MODE_RUN;
                end
            end
            default: begin
                nxt_mode = MODE_RUN;
            end
        endcase
    end

    // Keep decisions, sampled from the live enables at the stop request.
    assign keep_now[SLOT_ADC]    = adc_async_clock_enable && lvd_in_stop;
    assign keep_now[SLOT_COMP]   = comparator_enable
                                   && (!comparator_bandgap_select || lvd_in_stop);
    assign keep_now[SLOT_CLKGEN] = internal_ref_clock_enable && internal_ref_stop_enable;
    assign keep_now[SLOT_RTC]    = (rtc_prescale_select != 4'h0);
    assign keep_now[SLOT_OSC]    = external_ref_clock_enable && external_ref_stop_enable
                                   && (!osc_high_range || lvd_in_stop);
    assign keep_now[SLOT_USB]    = usb_module_enable && usb_phy_enable;

    // Only the counter survives deep stop; USB and the counter drop to off, not standby.
    assign deep_allowed = NUM_PERIPH'(1) << SLOT_RTC;

    assign in_light = (mode_ff == MODE_LIGHT_STOP);
    assign in_deep  = (mode_ff == MODE_DEEP_STOP);
    assign in_stop  = in_light || in_deep;

    // One policy instance per peripheral keeps the state logic in one place.
    generate
        for (genvar i = 0; i < NUM_PERIPH; i++) begin : g_periph
            assign light_fallback[i] = (i == SLOT_RTC || i == SLOT_USB) ? PERIPH_OFF
                                                                          : PERIPH_STANDBY;
            stop_periph_policy u_policy (
                .core_clk       (core_clk),
                .reset          (reset),
                .clk_en         (clk_en),
                .in_light       (nxt_mode == MODE_LIGHT_STOP),
                .in_deep        (nxt_mode == MODE_DEEP_STOP),
                .keep           (entering ? keep_now[i] : keep_ff[i]),
                .deep_allowed   (deep_allowed[i]),
                .light_fallback (light_fallback[i]),
                .state_ff       (periph_state[i])
            );
        end
    endgenerate

    assign adc_state_ff        = periph_state[SLOT_ADC];
    assign comparator_state_ff = periph_state[SLOT_COMP];
    assign clockgen_state_ff   = periph_state[SLOT_CLKGEN];
    assign rtc_state_ff        = periph_state[SLOT_RTC];
    assign osc_state_ff        = periph_state[SLOT_OSC];
    assign usb_state_ff        = periph_state[SLOT_USB];

    // Status image; bits above the fields read as zero.
    assign status_word = DATA_W'({debug_at_entry_ff && in_stop, regulator_active_ff,
                                  illegal_flag_ff, mode_ff});
    assign read_word   = hit(reg_addr, CTRL_OFFSET)   ? ctrl_ff     :
                         hit(reg_addr, STATUS_OFFSET) ? status_word :
                                                        {DATA_W{1'b0}};

    // Mode, entry snapshot and software registers.
    always_ff @(posedge core_clk) begin
        if (reset) begin
            mode_ff           <= MODE_RUN;
            ctrl_ff           <= CTRL_RESET;
            keep_ff           <= '0;
            debug_at_entry_ff <= 1'b0;
            lvd_at_entry_ff   <= 1'b0;
        end else if (clk_en) begin
            mode_ff <= nxt_mode;
            if (wr_ctrl) begin
                ctrl_ff <= reg_wdata;
            end
            if (entering) begin
                keep_ff           <= keep_now;
                debug_at_entry_ff <= debug_enable;
                lvd_at_entry_ff   <= lvd_in_stop;
            end
        end
    end

    // Sticky refusal flag: a new refusal beats a same-cycle software clear.
    always_ff @(posedge core_clk) begin
        if (reset) begin
            illegal_flag_ff <= 1'b0;
        end else if (clk_en) begin
            illegal_flag_ff <= stop_refused || (illegal_flag_ff && !clear_illegal);
        end
    end

    // Read data stand in the cycle after the strobe only.
    always_ff @(posedge core_clk) begin
        if (reset) begin
            reg_rdata_ff <= '0;
        end else if (clk_en) begin
            reg_rdata_ff <= reg_read ? read_word : {DATA_W{1'b0}};
        end
    end

    // Clock and power outputs are computed from the next mode so they move with it.
    always_ff @(posedge core_clk) begin
        if (reset) begin
            stop_mode_ff            <= MODE_RUN;
            periph_clock_run_ff     <= 1'b1;
            debug_clock_run_ff      <= 1'b1;
            regulator_active_ff     <= 1'b1;
            io_hold_ff              <= 1'b0;
            ram_retain_ff           <= 1'b0;
            usb_ram_retain_ff       <= 1'b0;
            standby_retain_ff       <= 1'b0;
            periph_power_off_ff     <= 1'b0;
            illegal_opcode_reset_ff <= 1'b0;
        end else if (clk_en) begin
            stop_mode_ff        <= nxt_mode;
            periph_clock_run_ff <= (nxt_mode == MODE_RUN);
            debug_clock_run_ff  <= (nxt_mode == MODE_RUN)
                                   || (entering ? debug_enable : debug_at_entry_ff);
            regulator_active_ff <= (nxt_mode == MODE_RUN)
                                   || (entering ? (debug_enable || lvd_in_stop)
                                               : (in_light && (debug_at_entry_ff
                                                               || lvd_at_entry_ff)));
            io_hold_ff          <= (nxt_mode != MODE_RUN);
            ram_retain_ff       <= (nxt_mode != MODE_RUN);
            usb_ram_retain_ff   <= (nxt_mode != MODE_RUN);
            standby_retain_ff   <= (nxt_mode == MODE_LIGHT_STOP);
            periph_power_off_ff <= (nxt_mode == MODE_DEEP_STOP);
            illegal_opcode_reset_ff <= stop_refused;
        end
    end

endmodule

`default_nettype wire

// ===== stop_periph_policy.sv
/*
 * One peripheral's power state while the controller runs or stops.
 * Assumes the caller presents a keep decision that was latched at stop entry.
 */
`timescale 1ns/1ps
`default_nettype none

module stop_periph_policy
    import stop_ctl_pkg::*;
(
    input  wire logic       core_clk,
    input  wire logic       reset,
    input  wire logic       clk_en,
    input  wire logic       in_light,
    input  wire logic       in_deep,
    input  wire logic       keep,
    input  wire logic       deep_allowed,
    input  wire logic [1:0] light_fallback,
    output logic      [1:0] state_ff
);

    logic [1:0] nxt_state;

    // Light stop keeps or parks the unit; deep stop powers it off unless allowed and kept.
    assign nxt_state = in_deep  ? ((deep_allowed && keep) ? PERIPH_ON : PERIPH_OFF) :
                       in_light ? (keep ? PERIPH_ON : light_fallback) :
                                  PERIPH_ON;

    // The state moves with the mode on the same edge, like every other output.
    always_ff @(posedge core_clk) begin
        if (reset) begin
            state_ff <= PERIPH_ON;
        end else if (clk_en) begin
            state_ff <= nxt_state;
        end
    end

endmodule

`default_nettype wire

// ===== tb_stop_mode_clock_gating.sv
/*
 * Self-checking bench for the stop-mode clock gating controller.
 * Assumes the package constants and the bound checker; the bench drives every port.
 */
`timescale 1ns/1ps
`default_nettype none

module tb_stop_mode_clock_gating
    import stop_ctl_pkg::*;
;
    logic        core_clk = 1'b0;
    logic        reset = 1'b1;
    logic        clk_en = 1'b1;
    logic [3:0]  reg_addr = 4'h0;
    logic [7:0]  reg_wdata = 8'h00;
    logic        reg_write = 1'b0;
    logic        reg_read = 1'b0;
    logic        stop_request = 1'b0;
    logic        wake_request = 1'b0;
    logic [16:0] cfg = 17'h00000;
    wire  [7:0]  rdata;
    wire  [1:0]  mode;
    wire  [11:0] states;
    wire  [7:0]  flags;
    wire         illegal;
    int          n_errors = 0;
    int          num_checks = 0;

    // A 100 ns clock period.
    always #50 core_clk = ~core_clk;

    stop_mode_clock_gating i_dut (.core_clk(core_clk), .reset(reset), .clk_en(clk_en),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
        .reg_rdata_ff(rdata), .stop_request(stop_request), .wake_request(wake_request),
        .debug_enable(cfg[0]), .lowvolt_detect_enable(cfg[1]), .lowvolt_stop_enable(cfg[2]),
        .adc_async_clock_enable(cfg[3]), .comparator_enable(cfg[4]),
        .comparator_bandgap_select(cfg[5]), .internal_ref_clock_enable(cfg[6]),
        .internal_ref_stop_enable(cfg[7]), .rtc_prescale_select(cfg[16:13]),
        .external_ref_clock_enable(cfg[8]), .external_ref_stop_enable(cfg[9]),
        .osc_high_range(cfg[10]), .usb_module_enable(cfg[11]), .usb_phy_enable(cfg[12]),
        .stop_mode_ff(mode), .periph_clock_run_ff(flags[7]), .debug_clock_run_ff(flags[6]),
        .regulator_active_ff(flags[5]), .io_hold_ff(flags[4]), .ram_retain_ff(flags[3]),
        .usb_ram_retain_ff(flags[2]), .standby_retain_ff(flags[1]),
        .periph_power_off_ff(flags[0]), .illegal_opcode_reset_ff(illegal),
        .adc_state_ff(states[1:0]), .comparator_state_ff(states[3:2]),
        .clockgen_state_ff(states[5:4]), .rtc_state_ff(states[7:6]),
        .osc_state_ff(states[9:8]), .usb_state_ff(states[11:10]));

    task automatic stop_test;
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic chk(input string name, input logic [11:0] exp, input logic [11:0] got);
        num_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge core_clk);
        reg_write <= 1'b0;
        // Leave the edge's time step so a following write never sets the strobe twice in it.
        #1;
    endtask

    // Read data stand only in the cycle after the strobe, so they are sampled there.
    task automatic rd(input logic [3:0] a, input logic [7:0] exp);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge core_clk);
        reg_read <= 1'b0;
        #1;
        chk("reg_rdata", {4'h0, exp}, {4'h0, rdata});
    endtask

    // Expected peripheral states; slot order is adc, comparator, clockgen, rtc, osc, usb.
    function automatic logic [11:0] exp_st(input logic [16:0] c, input logic deep);
        logic       low_voltage_detector;
        logic [5:0] k;
        logic [11:0] r;
        low_voltage_detector = c[1] & c[2];
        k = {c[11] & c[12], c[8] & c[9] & (!c[10] | low_voltage_detector), c[16:13] != 4'h0, c[6] & c[7],
             c[4] & (!c[5] | low_voltage_detector), c[3] & low_voltage_detector};
        for (int i = 0; i < 6; i++) begin
            r[2*i +: 2] = (deep && i != 3) ? PERIPH_OFF : k[i] ? PERIPH_ON :
                          (i == 3 || i == 5) ? PERIPH_OFF : PERIPH_STANDBY;
        end
        return r;
    endfunction

    task automatic reset_scn;
        chk("mode", 12'h000, {10'h0, mode});
        chk("flags", 12'h0e0, {4'h0, flags});
        chk("states", 12'haaa, states);
        rd(CTRL_OFFSET, CTRL_RESET);
        rd(STATUS_OFFSET, 8'h08);
        wr(CTRL_OFFSET, 8'hf1);
        wr(4'h7, 8'hff);
        rd(4'h7, 8'h00);
        rd(CTRL_OFFSET, 8'hf1);
    endtask

    // A frozen cycle must not take the request; the next one is refused.
    task automatic illegal_scn;
        wr(CTRL_OFFSET, 8'h02);
        clk_en <= 1'b0;
        stop_request <= 1'b1;
        @(posedge core_clk);
        clk_en <= 1'b1;
        #1;
        chk("frozen", 12'h000, {9'h0, illegal, mode});
        @(posedge core_clk);
        stop_request <= 1'b0;
        #1;
        chk("refused", 12'h004, {9'h0, illegal, mode});
        rd(STATUS_OFFSET, 8'h0c);
        wr(STATUS_OFFSET, 8'h04);
        rd(STATUS_OFFSET, 8'h08);
        chk("pulse", 12'h000, {11'h0, illegal});
    endtask

    // Enables are flipped during stop to show the entry decisions are latched.
    task automatic stop_case(input logic [7:0] ctrl, input logic [16:0] c);
        logic deep;
        logic low_voltage_detector;
        low_voltage_detector = c[1] & c[2];
        deep = ctrl[1] & !c[0] & !low_voltage_detector;
        wr(CTRL_OFFSET, ctrl);
        cfg <= c;
        stop_request <= 1'b1;
        @(posedge core_clk);
        stop_request <= 1'b0;
        #1;
        chk("mode", deep ? 12'h003 : 12'h001, {10'h0, mode});
        chk("flags", {5'h0, c[0], !deep & (c[0] | low_voltage_detector), 3'b111, !deep, deep},
            {4'h0, flags});
        chk("states", exp_st(c, deep), states);
        cfg <= ~c;
        rd(STATUS_OFFSET, {3'b000, c[0], !deep & (c[0] | low_voltage_detector), 1'b0,
            deep ? 2'h3 : 2'h1});
        chk("held", exp_st(c, deep), states);
        wake_request <= 1'b1;
        @(posedge core_clk);
        wake_request <= 1'b0;
        cfg <= 17'h00000;
        #1;
        chk("run", 12'h0e0, {mode, 2'h0, flags});
        chk("run states", 12'haaa, states);
    endtask

    initial begin
        repeat (16) @(posedge core_clk);
        reset <= 1'b0;
        @(posedge core_clk);
        #1;
        reset_scn();
        illegal_scn();
        stop_case(8'h01, 17'h00000);
        stop_case(8'h03, 17'h00000);
        stop_case(8'h03, 17'h00001);
        stop_case(8'h03, 17'h00006);
        stop_case(8'h03, 17'h00002);
        stop_case(8'h01, 17'h1fffe);
        stop_case(8'h01, 17'h1fff8);
        stop_case(8'h01, 17'h00b50);
        stop_case(8'h03, 17'h03ff8);
        stop_test();
    end

    // Watchdog well beyond the some 65 cycles the run needs.
    initial begin
        repeat (3000) @(posedge core_clk);
        n_errors++;
        stop_test();
    end
endmodule

`default_nettype wire
